/* File: verilog/ampm_pkg.sv */
// Purpose: Shared constants and types for the add-on address/pass-thru register block
// Assumes: Add-on bus and PCI side both run on the PCI clock
// Notes:   Offsets are add-on byte addresses
package ampm_pkg;
    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0]  OFS_MW_ADDR   = 8'h24;
    localparam logic [7:0]  OFS_PT_ADDR   = 8'h28;
    localparam logic [7:0]  OFS_PT_DATA   = 8'h2c;
    localparam logic [7:0]  OFS_MR_ADDR   = 8'h30;
    localparam logic [7:0]  OFS_MB_STATUS = 8'h34;
    localparam logic [31:0] RST_MW_ADDR   = 32'h00000000;
    localparam logic [31:0] RST_MR_ADDR   = 32'h00000000;
    localparam logic [31:0] RST_MB_STATUS = 32'h00000000;
    localparam logic [31:0] RST_PT        = 32'h00000000;
    // ------------------------------------------------------------------
    // Field layout and sizes
    // ------------------------------------------------------------------
    localparam int          DATA_W        = 32;
    localparam int          CNT_W         = 30;
    localparam int          MB_HALF       = 16;
    localparam int          FIFO_DEPTH    = 16;
    localparam logic [1:0]  DWORD_LSBS    = 2'h0;
    localparam logic [29:0] DWORD_STEP    = 30'h00000001;
    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        sel;
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } ampm_req_s;
    typedef struct packed {
        logic        hit;
        logic [3:0]  region;
        logic        is_wr;
        logic [31:0] addr;
        logic [31:0] wdata;
    } ampm_pthit_s;
    typedef enum logic [1:0] {
        PT_IDLE = 2'b00,
        PT_WR   = 2'b01,
        PT_RD   = 2'b10
    } ampm_pt_e;
endpackage

/* File: verilog/ampm_fifo.sv */
// Purpose: Synchronous FIFO with valid/ready on both sides
// Assumes: Single clock, depth a power of two
// Notes:   Full and empty are exact
`timescale 1ns/100ps
`default_nettype none
module ampm_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input  wire logic             i_core_clk, // Clock
    input  wire logic             i_rstn,     // Async reset, low
    input  wire logic             i_valid,    // Push request
    output logic                  o_ready,    // Not full
    input  wire logic [WIDTH-1:0] i_data,     // Push data
    output logic                  o_valid,    // Not empty
    input  wire logic             i_ready,    // Pop request
    output logic      [WIDTH-1:0] o_data      // Head word
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wptr;
    logic [AW:0]      rptr;
    wire              push = i_valid && o_ready;
    wire              pop  = o_valid && i_ready;
    assign o_ready = (wptr - rptr) != (AW+1)'(DEPTH);
    assign o_valid = wptr != rptr;
    assign o_data  = mem[rptr[AW-1:0]];
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wptr <= '0;
            rptr <= '0;
        end else begin
            if (push) wptr <= wptr + 1'b1;
            if (pop) rptr <= rptr + 1'b1;
        end
    end
    always_ff @(posedge i_core_clk) begin
        if (push) mem[wptr[AW-1:0]] <= i_data;
    end
endmodule
`default_nettype wire

/* File: verilog/ampm_regs.sv */
// Purpose: Add-on master address counters, pass-thru registers, mailbox status
// Assumes: PCI-side strobes are synchronous to i_core_clk
// Notes:   Add-on writes of pass-thru data queue in a 16-word FIFO
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// [RULE1] Master address registers reachable from add-on only with bus mastering enabled
// [RULE2] Master address counters are 30 bits, low two bits always zero
// [RULE3] Initiator starts master transfers DWORD aligned with non-zero byte count
// [RULE4] Write address counter always points at next unwritten PCI location
// [RULE5] Read address counter always points at next unread PCI location
// [RULE6] Master address registers readable mid-transfer to monitor progress
// [RULE7] Master address phase drives AD bits one and zero as zero
// [RULE8] Address bit A1 stays zero while master, signalling burst capability
// [RULE9] Pass-thru region hit captures address and asserts attention
// [RULE10] Wait states continue until data moves or initiator aborts
// [RULE11] Add-on reads data for PCI write hit, writes it for read hit
// [RULE12] Mailbox status: outgoing in upper half, incoming in lower half
// [RULE13] Status bit set when byte written, cleared when read by receiver
// [RULE14] Incoming carries PCI to add-on, outgoing carries add-on to PCI
// [RULE15] One bit per byte, mailbox four byte three highest in each half
// [RULE16] Each transferred DWORD advances the address counter by four bytes
module ampm_regs (
    input  wire logic                 i_core_clk,      // PCI clock
    input  wire logic                 i_rstn,          // Async reset, low
    input  wire ampm_pkg::ampm_req_s  i_req,           // Add-on register access
    output logic               [31:0] o_rdata,         // Add-on read data
    output logic                      o_rvalid,        // Read data valid pulse
    output logic                      o_ptd_wready,    // Pass-thru data FIFO has room
    input  wire logic                 i_master_en,     // Add-on bus mastering enabled
    input  wire logic                 i_mw_dword_done, // Master write DWORD done
    input  wire logic                 i_mr_dword_done, // Master read DWORD done
    output logic               [31:0] o_mw_pci_addr,   // Master write address phase
    output logic               [31:0] o_mr_pci_addr,   // Master read address phase
    input  wire ampm_pkg::ampm_pthit_s i_pt,           // PCI pass-thru hit
    input  wire logic                 i_pt_abort,      // Initiator aborted cycle
    input  wire logic                 i_pt_rready,     // PCI takes read data
    output logic                      o_pt_wait,       // Insert PCI wait states
    output logic               [31:0] o_pt_rdata,      // Data for PCI read hit
    output logic                      o_pt_rvalid,     // Read data offered
    output logic                      o_pt_done,       // Pass-thru completed pulse
    output logic                      o_passthru_attention_n, // Attention, low
    input  wire logic          [15:0] i_in_mb_wr,      // PCI wrote incoming bytes
    input  wire logic          [15:0] i_in_mb_rd,      // Add-on read incoming bytes
    input  wire logic          [15:0] i_out_mb_wr,     // Add-on wrote outgoing bytes
    input  wire logic          [15:0] i_out_mb_rd      // PCI read outgoing bytes
);
    // ------------------------------------------------------------------
    // Byte lane merge
    // ------------------------------------------------------------------
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  be);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return r;
    endfunction

    logic [29:0]        mw_cnt;
    logic [29:0]        mr_cnt;
    logic [31:0]        pt_addr;
    logic [31:0]        pt_data;
    logic [31:0]        mb_status;
    ampm_pkg::ampm_pt_e pt_state;
    ampm_pkg::ampm_pt_e next_pt_state;
    logic               fifo_out_valid;

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    wire wr_any  = i_req.sel && i_req.wr;
    wire rd_any  = i_req.sel && i_req.rd;
    wire hit_mw  = i_req.addr == ampm_pkg::OFS_MW_ADDR;
    wire hit_mr  = i_req.addr == ampm_pkg::OFS_MR_ADDR;
    wire hit_pta = i_req.addr == ampm_pkg::OFS_PT_ADDR;
    wire hit_ptd = i_req.addr == ampm_pkg::OFS_PT_DATA;
    wire hit_mb  = i_req.addr == ampm_pkg::OFS_MB_STATUS;

    // ------------------------------------------------------------------
    // Write and read strobes
    // ------------------------------------------------------------------
    wire wr_mw   = wr_any && hit_mw && i_master_en; // RULE1
    wire wr_mr   = wr_any && hit_mr && i_master_en; // RULE1
    wire wr_ptd  = wr_any && hit_ptd;
    wire rd_ptd  = rd_any && hit_ptd;

    // ------------------------------------------------------------------
    // Counter views and read select
    // ------------------------------------------------------------------
    wire [31:0] mw_full   = {mw_cnt, ampm_pkg::DWORD_LSBS}; // RULE2
    wire [31:0] mr_full   = {mr_cnt, ampm_pkg::DWORD_LSBS}; // RULE2
    wire [31:0] mw_merged = merge(mw_full, i_req.wdata, i_req.be);
    wire [31:0] mr_merged = merge(mr_full, i_req.wdata, i_req.be);

    wire [31:0] next_rdata =
        (hit_mw && i_master_en) ? mw_full :  // RULE1 RULE6
        (hit_mr && i_master_en) ? mr_full :  // RULE1 RULE6
        hit_pta ? pt_addr :
        hit_ptd ? pt_data :
        hit_mb  ? mb_status : 32'h00000000;

    // ------------------------------------------------------------------
    // Master address counters
    // ------------------------------------------------------------------
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            mw_cnt <= ampm_pkg::RST_MW_ADDR[31:2];
            mr_cnt <= ampm_pkg::RST_MR_ADDR[31:2];
        end else begin
            if (wr_mw) begin
                mw_cnt <= mw_merged[31:2]; // RULE1
            end else if (i_mw_dword_done) begin
                mw_cnt <= mw_cnt + ampm_pkg::DWORD_STEP; // RULE4 RULE16
            end
            if (wr_mr) begin
                mr_cnt <= mr_merged[31:2]; // RULE1
            end else if (i_mr_dword_done) begin
                mr_cnt <= mr_cnt + ampm_pkg::DWORD_STEP; // RULE5 RULE16
            end
        end
    end

    assign o_mw_pci_addr = mw_full; // RULE7 RULE8
    assign o_mr_pci_addr = mr_full; // RULE7 RULE8

    // ------------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------------
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rdata  <= 32'h00000000;
            o_rvalid <= 1'b0;
        end else begin
            o_rvalid <= rd_any;
            if (rd_any) begin
                o_rdata <= next_rdata; // RULE6
            end
        end
    end

    // ------------------------------------------------------------------
    // Pass-thru handshake
    // ------------------------------------------------------------------
    wire pt_take    = (pt_state == ampm_pkg::PT_IDLE) && i_pt.hit && (|i_pt.region);
    wire pt_rd_pop  = (pt_state == ampm_pkg::PT_RD) && fifo_out_valid && i_pt_rready;
    wire pt_wr_done = (pt_state == ampm_pkg::PT_WR) && rd_ptd;
    always_comb begin
        next_pt_state = pt_state;
        case (pt_state)
            ampm_pkg::PT_IDLE: begin
                if (pt_take) next_pt_state = i_pt.is_wr ? ampm_pkg::PT_WR : ampm_pkg::PT_RD; // RULE9
            end
            ampm_pkg::PT_WR: begin
                if (i_pt_abort || rd_ptd) next_pt_state = ampm_pkg::PT_IDLE; // RULE10 RULE11
            end
            ampm_pkg::PT_RD: begin
                if (i_pt_abort || pt_rd_pop) next_pt_state = ampm_pkg::PT_IDLE; // RULE10 RULE11
            end
            default: next_pt_state = ampm_pkg::PT_IDLE;
        endcase
    end

    // ------------------------------------------------------------------
    // Pass-thru capture
    // ------------------------------------------------------------------
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pt_state  <= ampm_pkg::PT_IDLE;
            pt_addr   <= ampm_pkg::RST_PT;
            pt_data   <= ampm_pkg::RST_PT;
            o_pt_done <= 1'b0;
        end else begin
            pt_state  <= next_pt_state;
            o_pt_done <= (pt_wr_done || pt_rd_pop) && !i_pt_abort;
            if (pt_take) begin
                pt_addr <= i_pt.addr; // RULE9
            end
            if (pt_take && i_pt.is_wr) begin
                pt_data <= i_pt.wdata;
            end else if (wr_ptd) begin
                pt_data <= i_req.wdata;
            end
        end
    end

    assign o_pt_wait              = pt_state != ampm_pkg::PT_IDLE; // RULE10
    assign o_passthru_attention_n = pt_state == ampm_pkg::PT_IDLE; // RULE9
    assign o_pt_rvalid            = (pt_state == ampm_pkg::PT_RD) && fifo_out_valid;

    // Add-on read responses queue here ahead of PCI reads
    ampm_fifo #(
        .WIDTH (ampm_pkg::DATA_W),
        .DEPTH (ampm_pkg::FIFO_DEPTH)
    ) u_ptd_fifo (
        .i_core_clk (i_core_clk),
        .i_rstn     (i_rstn),
        .i_valid    (wr_ptd), // RULE11
        .o_ready    (o_ptd_wready),
        .i_data     (i_req.wdata),
        .o_valid    (fifo_out_valid),
        .i_ready    (pt_rd_pop),
        .o_data     (o_pt_rdata)
    );

    // ------------------------------------------------------------------
    // Mailbox byte fill status
    // ------------------------------------------------------------------
    wire [31:0] mb_set = {i_out_mb_wr, i_in_mb_wr}; // RULE12 RULE14 RULE15
    wire [31:0] mb_clr = {i_out_mb_rd, i_in_mb_rd}; // RULE12 RULE14 RULE15
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            mb_status <= ampm_pkg::RST_MB_STATUS;
        end else begin
            mb_status <= (mb_status & ~mb_clr) | mb_set; // RULE13
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rstn);

    // ------------------------------------------------------------------
    // Checks: master address counters and read valid pulse
    // ------------------------------------------------------------------
    mw_locked_a: assert property ( // RULE1
        (wr_any && hit_mw && !i_master_en && !i_mw_dword_done)
        |=> $stable(o_mw_pci_addr))
        else $error("master write address changed while mastering disabled");

    mr_locked_a: assert property ( // RULE1
        (wr_any && hit_mr && !i_master_en && !i_mr_dword_done)
        |=> $stable(o_mr_pci_addr))
        else $error("master read address changed while mastering disabled");

    mw_align_a: assert property ( // RULE2
        o_mw_pci_addr[1:0] == 2'b00
        && o_mr_pci_addr[1:0] == 2'b00)
        else $error("master address not DWORD aligned");

    mw_load_a: assert property ( // RULE2
        wr_mw
        |=> o_mw_pci_addr == ($past(mw_merged) & 32'hffff_fffc))
        else $error("master write address load wrong");

    mw_step_a: assert property ( // RULE4
        (i_mw_dword_done && !wr_mw)
        |=> o_mw_pci_addr == $past(o_mw_pci_addr) + 32'h4)
        else $error("master write address did not advance by four");

    mr_step_a: assert property ( // RULE5
        (i_mr_dword_done && !wr_mr)
        |=> o_mr_pci_addr == $past(o_mr_pci_addr) + 32'h4)
        else $error("master read address did not advance by four");

    mon_read_a: assert property ( // RULE6
        (rd_any && hit_mw && i_master_en)
        |=> o_rvalid && o_rdata == $past(o_mw_pci_addr))
        else $error("master write address read mismatch");

    mr_read_a: assert property ( // RULE6
        (rd_any && hit_mr && i_master_en)
        |=> o_rvalid && o_rdata == $past(o_mr_pci_addr))
        else $error("master read address read mismatch");

    read_pulse_a: assert property ( // RULE6
        rd_any
        |=> o_rvalid)
        else $error("read data valid missing");

    // ------------------------------------------------------------------
    // Checks: pass-thru
    // ------------------------------------------------------------------
    pt_capture_a: assert property ( // RULE9
        pt_take
        |=> !o_passthru_attention_n && pt_addr == $past(i_pt.addr))
        else $error("pass-thru hit not captured");

    pt_hold_a: assert property ( // RULE10
        (pt_state == ampm_pkg::PT_WR && !rd_ptd && !i_pt_abort)
        |=> o_pt_wait)
        else $error("wait states dropped early");

    pt_rd_hold_a: assert property ( // RULE10
        (pt_state == ampm_pkg::PT_RD && !pt_rd_pop && !i_pt_abort)
        |=> o_pt_wait)
        else $error("read wait states dropped early");

    pt_abort_a: assert property ( // RULE10
        (o_pt_wait && i_pt_abort)
        |=> !o_pt_wait && !o_pt_done)
        else $error("abort did not end pass-thru cleanly");

    pt_wr_end_a: assert property ( // RULE11
        (pt_state == ampm_pkg::PT_WR && rd_ptd && !i_pt_abort)
        |=> !o_pt_wait && o_pt_done)
        else $error("pass-thru write not ended by data read");

    pt_rd_end_a: assert property ( // RULE11
        (pt_rd_pop && !i_pt_abort)
        |=> !o_pt_wait && o_pt_done)
        else $error("pass-thru read not ended by data pop");

    // ------------------------------------------------------------------
    // Checks: mailbox status
    // ------------------------------------------------------------------
    mb_set_a: assert property ( // RULE13
        mb_set[0]
        |=> mb_status[0])
        else $error("mailbox status set lost");

    mb_out_set_a: assert property ( // RULE14
        mb_set[31]
        |=> mb_status[31])
        else $error("outgoing mailbox status set lost");

    mb_clear_a: assert property ( // RULE13
        (mb_clr[31] && !mb_set[31])
        |=> !mb_status[31])
        else $error("mailbox status not cleared");

    mb_in_clear_a: assert property ( // RULE13
        (mb_clr[0] && !mb_set[0])
        |=> !mb_status[0])
        else $error("incoming mailbox status not cleared");

    mb_set_wins_a: assert property ( // RULE13
        (mb_set[16] && mb_clr[16])
        |=> mb_status[16])
        else $error("mailbox set lost to same-cycle clear");

    // ------------------------------------------------------------------
    // Cover points
    // ------------------------------------------------------------------
    pt_write_c: cover property (pt_take && i_pt.is_wr ##[1:20] pt_wr_done);
    pt_read_c: cover property (pt_take && !i_pt.is_wr ##[1:20] pt_rd_pop);
    fifo_full_c: cover property (!o_ptd_wready);
    mw_run_c: cover property (wr_mw ##1 i_mw_dword_done [*3]);
    pt_abort_c: cover property (o_pt_wait && i_pt_abort);
endmodule
`default_nettype wire

/* File: verification/ampm_pci_agent.sv */
// Purpose: PCI-side agent for pass-thru hits, read pops and master DWORD strobes
// Assumes: Bench commands it through its tasks
// Notes:   Released hit bus shows zero region and inverted other fields
`timescale 1ns/100ps
`default_nettype none
module ampm_pci_agent (
    input  wire logic                i_core_clk,  // Clock
    input  wire logic                i_pt_rvalid, // Read data offered
    input  wire logic         [31:0] i_pt_rdata,  // Read data
    output var ampm_pkg::ampm_pthit_s o_pt,       // Hit bus
    output logic                     o_pt_abort,  // Initiator abort
    output logic                     o_pt_rready, // Takes read data
    output logic                     o_mw_done,   // Write DWORD moved
    output logic                     o_mr_done    // Read DWORD moved
);
    int          stall = 0;
    logic [31:0] popped;
    initial begin
        o_pt = '0;
        o_pt_abort = 1'b0;
        o_pt_rready = 1'b0;
        o_mw_done = 1'b0;
        o_mr_done = 1'b0;
    end
    task automatic hit(input logic wr, input logic [3:0] rgn, input logic [31:0] a,
                       input logic [31:0] d);
        @(posedge i_core_clk);
        o_pt <= '{1'b1, rgn, wr, a, d};
        @(posedge i_core_clk);
        o_pt <= '{1'b0, 4'h0, ~wr, ~a, ~d};
    endtask
    // Nonzero count, base aligned by the counters' zero low bits
    task automatic dwords(input logic wr, input int n);
        repeat (n) begin
            @(posedge i_core_clk);
            o_mw_done <= wr;
            o_mr_done <= !wr;
        end
        @(posedge i_core_clk);
        o_mw_done <= 1'b0;
        o_mr_done <= 1'b0;
    endtask
    task automatic abort_cycle;
        @(posedge i_core_clk);
        o_pt_abort <= 1'b1;
        @(posedge i_core_clk);
        o_pt_abort <= 1'b0;
    endtask
    // Pop offered read data after a chosen stall
    initial forever begin
        @(posedge i_core_clk);
        if (i_pt_rvalid === 1'b1) begin
            repeat (stall) @(posedge i_core_clk);
            o_pt_rready <= 1'b1;
            @(posedge i_core_clk);
            popped = i_pt_rdata;
            o_pt_rready <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* File: verification/test_ampm_regs.sv */
// Purpose: Self-checking bench for the address, pass-thru and mailbox registers
// Assumes: Single 50 MHz clock
// Notes:   Pass-thru FIFO is filled to refusal and drained by read hits
`timescale 1ns/100ps
`default_nettype none
module test_ampm_regs;
    logic i_core_clk, i_rstn, master_en, abrt, rrdy, mwd, mrd, rvalid, room, ptw, ptv, ptd, attn_n;
    ampm_pkg::ampm_req_s   req;
    ampm_pkg::ampm_pthit_s pt;
    logic [15:0] in_wr, in_rd, out_wr, out_rd;
    logic [31:0] rdata, mw_pci, mr_pci, pt_rdata;
    int err_count = 0, n_tests = 0, n_done = 0, cyc = 0;
    ampm_regs dut_u (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_req(req), .o_rdata(rdata),
        .o_rvalid(rvalid), .o_ptd_wready(room), .i_master_en(master_en),
        .i_mw_dword_done(mwd), .i_mr_dword_done(mrd), .o_mw_pci_addr(mw_pci),
        .o_mr_pci_addr(mr_pci), .i_pt(pt), .i_pt_abort(abrt), .i_pt_rready(rrdy),
        .o_pt_wait(ptw), .o_pt_rdata(pt_rdata), .o_pt_rvalid(ptv), .o_pt_done(ptd),
        .o_passthru_attention_n(attn_n), .i_in_mb_wr(in_wr), .i_in_mb_rd(in_rd),
        .i_out_mb_wr(out_wr), .i_out_mb_rd(out_rd));
    ampm_pci_agent pci_u (.i_core_clk(i_core_clk), .i_pt_rvalid(ptv), .i_pt_rdata(pt_rdata),
        .o_pt(pt), .o_pt_abort(abrt), .o_pt_rready(rrdy), .o_mw_done(mwd), .o_mr_done(mrd));
    initial begin
        i_core_clk = 1'b0;
        forever #10 i_core_clk = ~i_core_clk;
    end
    always @(posedge i_core_clk) begin
        cyc++;
        if (ptd === 1'b1) n_done++;
        if (cyc == 20000) begin
            err_count++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] seen);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic chk1(input string what, input logic exp, input logic seen);
        chk32(what, {31'h0, exp}, {31'h0, seen});
    endtask
    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        @(posedge i_core_clk);
        req <= '{1'b1, 1'b1, 1'b0, a, be, d};
        @(posedge i_core_clk);
        req <= '0;
    endtask
    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        @(posedge i_core_clk);
        req <= '{1'b1, 1'b0, 1'b1, a, 4'hf, 32'h0};
        @(posedge i_core_clk);
        req <= '0;
        #1;
        chk1("read valid", 1'b1, rvalid);
        chk32(what, exp, rdata);
    endtask
    task automatic mb(input logic [15:0] iw, input logic [15:0] ir, input logic [15:0] ow,
                      input logic [15:0] orr);
        @(posedge i_core_clk);
        {in_wr, in_rd, out_wr, out_rd} <= {iw, ir, ow, orr};
        @(posedge i_core_clk);
        {in_wr, in_rd, out_wr, out_rd} <= '0;
    endtask
    task automatic wait_done;
        int k;
        k = 0;
        while (ptd !== 1'b1 && k < 40) begin
            @(posedge i_core_clk);
            #1;
            k++;
        end
        chk1("pt done", 1'b1, ptd);
    endtask
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        i_rstn = 1'b0;
        master_en = 1'b0;
        req = '0;
        {in_wr, in_rd, out_wr, out_rd} = '0;
        repeat (6) @(posedge i_core_clk);
        i_rstn <= 1'b1;
        #1;
        chk32("mw reset", ampm_pkg::RST_MW_ADDR, mw_pci);
        chk1("attention idle", 1'b1, attn_n);
        wr(ampm_pkg::OFS_MW_ADDR, 4'hf, 32'h0000_1000);
        rdchk("mw disabled", ampm_pkg::OFS_MW_ADDR, 32'h0);
        @(posedge i_core_clk);
        master_en <= 1'b1;
        rdchk("mw write gated", ampm_pkg::OFS_MW_ADDR, 32'h0);
        wr(ampm_pkg::OFS_MW_ADDR, 4'hf, 32'h8000_0103);
        rdchk("mw low bits", ampm_pkg::OFS_MW_ADDR, 32'h8000_0100);
        chk32("mw address phase", 32'h8000_0100, mw_pci);
        pci_u.dwords(1'b1, 3);
        rdchk("mw progress", ampm_pkg::OFS_MW_ADDR, 32'h8000_010c);
        wr(ampm_pkg::OFS_MW_ADDR, 4'h2, 32'h0000_5500);
        rdchk("mw byte lane", ampm_pkg::OFS_MW_ADDR, 32'h8000_550c);
        wr(ampm_pkg::OFS_MR_ADDR, 4'hf, 32'hffff_fff8);
        pci_u.dwords(1'b0, 3);
        rdchk("mr wrap", ampm_pkg::OFS_MR_ADDR, 32'h0000_0004);
        chk32("mr address phase", 32'h0000_0004, mr_pci);
        rdchk("unmapped", 8'h3c, 32'h0);
        wr(ampm_pkg::OFS_MB_STATUS, 4'hf, 32'hffff_ffff);
        for (int i = 0; i < 16; i++) begin
            mb(16'h0001 << i, 16'h0, 16'h8000 >> i, 16'h0);
            rdchk("mb full", ampm_pkg::OFS_MB_STATUS, {16'h8000 >> i, 16'h0001 << i});
            mb(16'h0, 16'h0001 << i, 16'h0, 16'h8000 >> i);
            rdchk("mb empty", ampm_pkg::OFS_MB_STATUS, 32'h0);
        end
        pci_u.hit(1'b1, 4'h2, 32'h0000_2468, 32'hcafe_0001);
        @(posedge i_core_clk);
        #1;
        chk1("pt attention", 1'b0, attn_n);
        rdchk("pt address", ampm_pkg::OFS_PT_ADDR, 32'h0000_2468);
        chk1("pt wait held", 1'b1, ptw);
        rdchk("pt write data", ampm_pkg::OFS_PT_DATA, 32'hcafe_0001);
        chk1("pt write done", 1'b1, ptd);
        chk1("pt wait end", 1'b0, ptw);
        for (int i = 0; i < 16; i++) wr(ampm_pkg::OFS_PT_DATA, 4'hf, 32'h5000_0000 + i);
        #1;
        chk1("fifo full", 1'b0, room);
        wr(ampm_pkg::OFS_PT_DATA, 4'hf, 32'hdead_0000);
        for (int i = 0; i < 16; i++) begin
            pci_u.stall = i % 3;
            pci_u.hit(1'b0, 4'h1 << (i % 4), 32'h0000_0100 + 4 * i, 32'h0);
            wait_done();
            chk32("pt read data", 32'h5000_0000 + i, pci_u.popped);
        end
        chk1("fifo drained", 1'b0, ptv);
        chk1("fifo room", 1'b1, room);
        pci_u.hit(1'b0, 4'h8, 32'h0000_3000, 32'h0);
        @(posedge i_core_clk);
        #1;
        chk1("abort pending", 1'b1, ptw);
        pci_u.abort_cycle();
        repeat (2) @(posedge i_core_clk);
        #1;
        chk1("abort wait end", 1'b0, ptw);
        chk1("abort attention", 1'b1, attn_n);
        chk32("done pulses", 32'd17, n_done);
        tally_and_finish();
    end
endmodule
`default_nettype wire
